// ==== rtl/irq_flag_pkg.sv ====
// constants for the interrupt request flag bank
// assumes a 32-bit axi4-lite register bus and same-clock event sources
package irq_flag_pkg;
	localparam int FLAG_W = 16;
	localparam int STRB_W = 2;
	localparam int GROUPS = 3;

	// register byte offsets, one aligned word each
	localparam logic [11:0] OFS_GROUP0 = 12'h000;
	localparam logic [11:0] OFS_GROUP1 = 12'h004;
	localparam logic [11:0] OFS_GROUP2 = 12'h008;
	localparam logic [1:0] IDX_NONE = 2'h3;

	// implemented bit masks per group, index is group number
	localparam logic [GROUPS-1:0][FLAG_W-1:0] GRP_MASK = {
		16'h22e3, 16'hfe1f, 16'h3fef};
	localparam logic [FLAG_W-1:0] FLAG_RESET = 16'h0000;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

	// vector order bits
	// group0 bit positions
	// adc done position
	localparam int ADC_DONE_FLAG = 13;
	localparam int UART_A_TX_FLAG = 12;
	localparam int UART_A_RX_FLAG = 11;
	localparam int SPI_A_EVENT_FLAG = 10;
	localparam int SPI_A_FAULT_FLAG = 9;
	localparam int TIMER_C_FLAG = 8;
	localparam int TIMER_B_FLAG = 7;
	localparam int COMPARE_B_FLAG = 6;
	localparam int CAPTURE_B_FLAG = 5;
	localparam int TIMER_A_FLAG = 3;
	localparam int COMPARE_A_FLAG = 2;
	localparam int CAPTURE_A_FLAG = 1;
	localparam int EXT_IRQ_A_FLAG = 0;
	// group1 bit positions
	// uart b pair
	localparam int UART_B_TX_FLAG = 15;
	localparam int UART_B_RX_FLAG = 14;
	localparam int EXT_IRQ_C_FLAG = 13;
	localparam int TIMER_E_FLAG = 12;
	localparam int TIMER_D_FLAG = 11;
	localparam int COMPARE_D_FLAG = 10;
	localparam int COMPARE_C_FLAG = 9;
	localparam int EXT_IRQ_B_FLAG = 4;
	localparam int PIN_CHANGE_FLAG = 3;
	localparam int COMPARATOR_FLAG = 2;
	localparam int I2C_A_MASTER_FLAG = 1;
	localparam int I2C_A_SLAVE_FLAG = 0;
	// group2 bit positions
	// parallel port, compare e
	localparam int PARALLEL_PORT_FLAG = 13;
	localparam int COMPARE_E_FLAG = 9;
	localparam int CAPTURE_E_FLAG = 7;
	localparam int CAPTURE_D_FLAG = 6;
	localparam int CAPTURE_C_FLAG = 5;
	localparam int SPI_B_EVENT_FLAG = 1;
	localparam int SPI_B_FAULT_FLAG = 0;
endpackage

// ==== rtl/flag_set_if.sv ====
// carrier between the bus front end and one flag group
// assumes a single clock shared by both ends
`timescale 1ns/100ps
`default_nettype none
interface flag_set_if;
	logic wr_en;
	logic [irq_flag_pkg::FLAG_W-1:0] wr_data;
	logic [irq_flag_pkg::STRB_W-1:0] wr_strb;
	logic [irq_flag_pkg::FLAG_W-1:0] set;
	logic [irq_flag_pkg::FLAG_W-1:0] flags;
	modport ctrl (output wr_en, output wr_data, output wr_strb,
		output set, input flags);
	modport bank (input wr_en, input wr_data, input wr_strb,
		input set, output flags);
endinterface
`default_nettype wire

// ==== rtl/flag_bank.sv ====
// one 16-bit group of sticky interrupt request flags
// assumes set pulses and write strobes come from the aclk domain
`timescale 1ns/100ps
`default_nettype none
module flag_bank #(
	parameter logic [irq_flag_pkg::FLAG_W-1:0] IMPL_MASK = 16'hffff
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write and event side
	flag_set_if.bank bus
);
	logic [irq_flag_pkg::FLAG_W-1:0] flag_q;

	////////////////////////////////////////////////////////////////////
	// one flop per bit; unimplemented bits stay constant zero
	for (genvar i = 0; i < irq_flag_pkg::FLAG_W; i++) begin : bitq
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				flag_q[i] <= irq_flag_pkg::FLAG_RESET[i];
			end else if (!IMPL_MASK[i]) begin
				flag_q[i] <= 1'b0;
			end else if (bus.set[i]) begin
				flag_q[i] <= 1'b1;
			end else if (bus.wr_en && bus.wr_strb[i/8]) begin
				flag_q[i] <= bus.wr_data[i];
			end
		end
	end

	assign bus.flags = flag_q;
endmodule
`default_nettype wire

// ==== rtl/interrupt_flag_status_bank.sv ====
// interrupt request flag bank: three groups behind an axi4-lite slave
// assumes event lines are one-cycle or level requests on aclk
// Behaviour
// - flag one means request occurred
// - flags read/write, reset zero, holes zero
// - group0 bit13 adc done, 15-14 empty
// - group0 bits 12/11 uart a tx/rx
// - group0 bits 10/9 spi a event/fault
// - group0 bits 8,7,3 timers c,b,a
// - group0 compare bits 6/2, capture 5/1
// - group0 bit0 ext irq a, bit4 empty
// - group1 bits 15/14 uart b tx/rx
// - group1 bit13 ext c, bit4 ext b
// - group1 timers 12/11, compares 10/9, 8-5 empty
// - group1 bit3 pin change, bit2 comparator
// - group1 bits 1/0 i2c a master/slave
// - group2 bit13 parallel port, bit9 compare e
// - group2 bits 7,6,5 captures e,d,c
// - group2 bits 1/0 spi b, 4-2 empty
// - bits follow vector number order
`timescale 1ns/100ps
`default_nettype none
module interrupt_flag_status_bank #(
	parameter int ADDR_W = 12
) (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// axi4-lite write address
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// axi4-lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// axi4-lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read address
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// axi4-lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// peripheral event lines, one bit per flag position
	input wire logic [15:0] set_group0,
	input wire logic [15:0] set_group1,
	input wire logic [15:0] set_group2,
	// flag state toward the cpu interrupt logic
	output logic [15:0] flags_group0,
	output logic [15:0] flags_group1,
	output logic [15:0] flags_group2
);
	localparam int FW = irq_flag_pkg::FLAG_W;
	localparam int NG = irq_flag_pkg::GROUPS;

	logic awready_q;
	logic wready_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic arready_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_q;
	logic do_write;
	logic [1:0] wr_idx;
	logic [1:0] rd_idx;
	logic [NG-1:0][FW-1:0] set_all;
	logic [NG-1:0][FW-1:0] flags_all;

	////////////////////////////////////////////////////////////////////
	// address decode: word aligned, low two bits ignored
	function automatic logic [1:0] reg_idx(input logic [ADDR_W-1:0] a);
		logic [11:0] w;
		w = {a[11:2], 2'b00};
		if (w == irq_flag_pkg::OFS_GROUP0) begin
			return 2'd0;
		end else if (w == irq_flag_pkg::OFS_GROUP1) begin
			return 2'd1;
		end else if (w == irq_flag_pkg::OFS_GROUP2) begin
			return 2'd2;
		end
		return irq_flag_pkg::IDX_NONE;
	endfunction

	// upper address bits must be zero for a hit
	function automatic logic [1:0] full_idx(input logic [ADDR_W-1:0] a);
		if ((a >> 12) != '0) begin
			return irq_flag_pkg::IDX_NONE;
		end
		return reg_idx(a);
	endfunction

	assign wr_idx = full_idx(awaddr_q);
	assign rd_idx = full_idx(s_axi_araddr);

	////////////////////////////////////////////////////////////////////
	// write address capture; held until the response is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			awaddr_q <= '0;
		end else if (s_axi_awvalid && awready_q) begin
			awready_q <= 1'b0;
			awaddr_q <= s_axi_awaddr;
		end else if (bvalid_q && s_axi_bready) begin
			awready_q <= 1'b1;
		end
	end

	// write data capture, independent of the address channel
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			wready_q <= 1'b1;
			wdata_q <= irq_flag_pkg::WORD_ZERO;
			wstrb_q <= 4'h0;
		end else if (s_axi_wvalid && wready_q) begin
			wready_q <= 1'b0;
			wdata_q <= s_axi_wdata;
			wstrb_q <= s_axi_wstrb;
		end else if (bvalid_q && s_axi_bready) begin
			wready_q <= 1'b1;
		end
	end

	// commit once both halves are held; one write at a time
	assign do_write = !awready_q && !wready_q && !bvalid_q;

	// write response; unmapped words answer slverr and change nothing
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= irq_flag_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			if (wr_idx == irq_flag_pkg::IDX_NONE) begin
				bresp_q <= irq_flag_pkg::RESP_SLVERR;
			end else begin
				bresp_q <= irq_flag_pkg::RESP_OKAY;
			end
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read path: data sampled at the address handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rresp_q <= irq_flag_pkg::RESP_OKAY;
			rdata_q <= irq_flag_pkg::WORD_ZERO;
		end else if (s_axi_arvalid && arready_q) begin
			arready_q <= 1'b0;
			rvalid_q <= 1'b1;
			if (rd_idx == irq_flag_pkg::IDX_NONE) begin
				rresp_q <= irq_flag_pkg::RESP_SLVERR;
				rdata_q <= irq_flag_pkg::WORD_ZERO;
			end else begin
				rresp_q <= irq_flag_pkg::RESP_OKAY;
				rdata_q <= {16'h0000, flags_all[rd_idx]};
			end
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_q <= 1'b0;
			arready_q <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// flag groups; the masks hold each unimplemented position at zero
	assign set_all = {set_group2, set_group1, set_group0};

	for (genvar g = 0; g < NG; g++) begin : grp
		flag_set_if bus ();
		flag_bank #(
			.IMPL_MASK(irq_flag_pkg::GRP_MASK[g])
		) u_bank (
			.aclk(aclk),
			.aresetn(aresetn),
			.bus(bus)
		);
		assign bus.wr_en = do_write && (wr_idx == 2'(g));
		assign bus.wr_data = wdata_q[FW-1:0];
		assign bus.wr_strb = wstrb_q[1:0];
		assign bus.set = set_all[g];
		assign flags_all[g] = bus.flags;
	end

	////////////////////////////////////////////////////////////////////
	// outputs, all straight from flops
	assign s_axi_awready = awready_q;
	assign s_axi_wready = wready_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = arready_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	assign flags_group0 = flags_all[0];
	assign flags_group1 = flags_all[1];
	assign flags_group2 = flags_all[2];

	////////////////////////////////////////////////////////////////////
	// checks on the flag and bus behaviour
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// a committed write on one group
	sequence s_commit_g1;
		do_write && (wr_idx == 2'd1);
	endsequence

	// a committed write that clears all of group1
	sequence s_clear_g1;
		s_commit_g1 ##0 (wstrb_q[1:0] == 2'h3)
			&& (wdata_q[15:0] == 16'h0000) && (set_group1 == 16'h0000);
	endsequence

	// a read of group0 accepted
	sequence s_read_g0;
		s_axi_arvalid && arready_q && (rd_idx == 2'd0);
	endsequence

	property p_reset_zero;
		$rose(aresetn) |-> (flags_group0 == 16'h0000)
			&& (flags_group1 == 16'h0000) && (flags_group2 == 16'h0000);
	endproperty
	a_reset_zero: assert property (p_reset_zero)
		else $error("flags not zero after reset");

	property p_holes0;
		(flags_group0 & ~irq_flag_pkg::GRP_MASK[0]) == 16'h0000;
	endproperty
	a_holes0: assert property (p_holes0)
		else $error("group0 unimplemented bit set");

	property p_holes1;
		(flags_group1 & ~irq_flag_pkg::GRP_MASK[1]) == 16'h0000;
	endproperty
	a_holes1: assert property (p_holes1)
		else $error("group1 unimplemented bit set");

	property p_holes2;
		(flags_group2 & ~irq_flag_pkg::GRP_MASK[2]) == 16'h0000;
	endproperty
	a_holes2: assert property (p_holes2)
		else $error("group2 unimplemented bit set");

	property p_set_adc;
		set_group0[irq_flag_pkg::ADC_DONE_FLAG]
			|=> flags_group0[irq_flag_pkg::ADC_DONE_FLAG];
	endproperty
	a_set_adc: assert property (p_set_adc)
		else $error("adc event lost");

	property p_set_uart_b;
		set_group1[irq_flag_pkg::UART_B_TX_FLAG]
			|=> flags_group1[irq_flag_pkg::UART_B_TX_FLAG] [*1]
			##1 1'b1;
	endproperty
	a_set_uart_b: assert property (p_set_uart_b)
		else $error("uart b tx event not flagged");

	property p_sticky_spi_b;
		flags_group2[irq_flag_pkg::SPI_B_FAULT_FLAG] && !do_write
			|=> flags_group2[irq_flag_pkg::SPI_B_FAULT_FLAG];
	endproperty
	a_sticky_spi_b: assert property (p_sticky_spi_b)
		else $error("spi b fault flag dropped without write");

	property p_clear_g1;
		s_clear_g1 |=> (flags_group1 == 16'h0000) && s_axi_bvalid
			&& (s_axi_bresp == irq_flag_pkg::RESP_OKAY);
	endproperty
	a_clear_g1: assert property (p_clear_g1)
		else $error("write of zero did not clear group1");

	property p_read_g0;
		s_read_g0 |=> s_axi_rvalid
			&& (s_axi_rdata == {16'h0000, $past(flags_group0)});
	endproperty
	a_read_g0: assert property (p_read_g0)
		else $error("group0 read data wrong");

	property p_bvalid_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
			&& $stable(s_axi_bresp);
	endproperty
	a_bvalid_hold: assert property (p_bvalid_hold)
		else $error("write response dropped early");

	property p_unmapped_wr;
		do_write && (wr_idx == irq_flag_pkg::IDX_NONE) && !(|set_all)
			|=> (s_axi_bresp == irq_flag_pkg::RESP_SLVERR)
			&& $stable(flags_all);
	endproperty
	a_unmapped_wr: assert property (p_unmapped_wr)
		else $error("unmapped write changed flags");
endmodule
`default_nettype wire

// ==== verification/event_source_model.sv ====
// event source model: stands in for the peripheral request lines
// assumes the bench asks for events on aclk, one group at a time
`timescale 1ns/100ps
`default_nettype none
module event_source_model (
	// clock
	input wire logic aclk,
	// bench request, held for as many cycles as the event lasts
	input wire logic fire,
	input wire logic [1:0] fire_grp,
	input wire logic [15:0] fire_bits,
	// event lines toward the flag bank
	output logic [15:0] set_group0,
	output logic [15:0] set_group1,
	output logic [15:0] set_group2
);
	// registered lines, idle low; a slow source simply holds fire longer
	always_ff @(posedge aclk) begin
		set_group0 <= (fire && fire_grp == 2'h0) ? fire_bits : 16'h0000;
		set_group1 <= (fire && fire_grp == 2'h1) ? fire_bits : 16'h0000;
		set_group2 <= (fire && fire_grp == 2'h2) ? fire_bits : 16'h0000;
	end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// self-checking bench for the interrupt flag bank
// assumes the event model and an axi4-lite master built in here
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, fire;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, fire_grp, r;
	logic [15:0] fire_bits, sg0, sg1, sg2, fg0, fg1, fg2;
	logic [15:0] um [3];
	int n_fail, cmp_count, cyc;
	typedef struct packed {logic [1:0] g; logic [15:0] m;} row_s;
	// one row per group of named flags: group, expected bits
	row_s rows [14] = '{
		'{2'h0, 16'h2000},
		'{2'h0, 16'h1800},
		'{2'h0, 16'h0600},
		'{2'h0, 16'h0188},
		'{2'h0, 16'h0066},
		'{2'h0, 16'h0001},
		'{2'h1, 16'hc000},
		'{2'h1, 16'h2010},
		'{2'h1, 16'h1e00},
		'{2'h1, 16'h000c},
		'{2'h1, 16'h0003},
		'{2'h2, 16'h2200},
		'{2'h2, 16'h00e0},
		'{2'h2, 16'h0003}};

	////////////////////////////////////////////////////////////////////////
	// design and event sources; prot unused by the block, so tied off
	interrupt_flag_status_bank uut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .set_group0(sg0), .set_group1(sg1),
		.set_group2(sg2), .flags_group0(fg0), .flags_group1(fg1),
		.flags_group2(fg2));
	event_source_model src (.aclk(aclk), .fire(fire), .fire_grp(fire_grp),
		.fire_bits(fire_bits), .set_group0(sg0), .set_group1(sg1),
		.set_group2(sg2));

	////////////////////////////////////////////////////////////////////////
	// 200 mhz clock and a hang guard well above the expected run
	always #2.5 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_fail++;
			complete_run();
		end
	end

	function automatic logic [15:0] flg(input logic [1:0] g);
		return (g == 2'h0) ? fg0 : (g == 2'h1) ? fg1 : fg2;
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// write: aw and w offered together, each dropped when taken
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] resp);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while ((awvalid && !awready) || (wvalid && !wready));
		do @(posedge aclk); while (!bvalid);
		resp = bresp;
	endtask

	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
		input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		do @(posedge aclk); while (!rvalid);
		check(rdata, e);
		check(32'(rresp), 32'(er));
	endtask

	// one-cycle event; flags are settled two edges after the model fires
	task automatic fire_ev(input logic [1:0] g, input logic [15:0] b);
		fire <= 1'b1;
		fire_grp <= g;
		fire_bits <= b;
		@(posedge aclk);
		fire <= 1'b0;
		repeat (2) @(posedge aclk);
	endtask

	task automatic complete_run;
		$display("mismatches %0d comparisons %0d", n_fail, cmp_count);
		if (n_fail == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence: table of named flags, then holes, strobes, errors
	initial begin
		{aclk, aresetn, awvalid, wvalid, arvalid, fire} = '0;
		{awaddr, araddr, wdata, wstrb, fire_grp, fire_bits} = '0;
		{bready, rready} = 2'b11;
		{n_fail, cmp_count, cyc} = '0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check({16'h0000, fg0 | fg1 | fg2}, 32'h0000_0000);
		for (int i = 0; i < 14; i++) begin
			fire_ev(rows[i].g, rows[i].m);
			check({16'h0000, flg(rows[i].g)}, {16'h0000, rows[i].m});
			rd_chk({8'h00, rows[i].g, 2'h0}, {16'h0000, rows[i].m},
				irq_flag_pkg::RESP_OKAY);
			axi_wr({8'h00, rows[i].g, 2'h0}, 32'h0000_0000, 4'h3, r);
			check({16'h0000, flg(rows[i].g)}, 32'h0000_0000);
		end
		// holes ignore events and read zero after writing all ones
		for (int g = 0; g < 3; g++) begin
			um[g] = 16'h0000;
			foreach (rows[i]) if (rows[i].g == 2'(g)) um[g] |= rows[i].m;
			fire_ev(2'(g), ~um[g]);
			check({16'h0000, flg(2'(g))}, 32'h0000_0000);
			axi_wr({8'h00, 2'(g), 2'h0}, 32'hffff_ffff, 4'hf, r);
			rd_chk({8'h00, 2'(g), 2'h0}, {16'h0000, um[g]},
				irq_flag_pkg::RESP_OKAY);
		end
		// every byte lane except lane 0 is strobed, low byte must survive
		axi_wr(12'h000, 32'h0000_0000, 4'he, r);
		check(32'(r), 32'(irq_flag_pkg::RESP_OKAY));
		check({16'h0000, fg0}, {16'h0000, um[0] & 16'h00ff});
		// unmapped word: error, no side effect
		axi_wr(12'h00c, 32'h0000_0000, 4'hf, r);
		check(32'(r), 32'(irq_flag_pkg::RESP_SLVERR));
		check({16'h0000, fg0}, {16'h0000, um[0] & 16'h00ff});
		rd_chk(12'h00c, 32'h0000_0000, irq_flag_pkg::RESP_SLVERR);
		// event lands on the commit edge of a clearing write
		axi_wr(12'h004, 32'h0000_0000, 4'h3, r);
		fork
			axi_wr(12'h004, 32'h0000_0000, 4'h3, r);
			fire_ev(2'h1, 16'h8000);
		join
		check({16'h0000, fg1}, 32'h0000_8000);
		// low address bits are ignored, so this still hits group1
		rd_chk(12'h006, 32'h0000_8000, irq_flag_pkg::RESP_OKAY);
		// reset in mid-run clears every flag
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		check({16'h0000, fg0 | fg1 | fg2}, 32'h0000_0000);
		complete_run();
	end
endmodule
`default_nettype wire
